// [bench/dl_remote_term.sv]
// remote terminal model: watches the outgoing link, sends inbound traffic
`timescale 1ns/100ps
module dl_remote_term (
  // clock
  input  wire logic clock,
  // data link
  input  wire logic bitTick,
  input  wire logic txBit,
  output logic      rxPin
);
  logic [7:0] txHist = 8'h00;
  int         onesRun = 0;
  int         maxRun = 0;
  int         flagCnt = 0;
  int         stuffRun = 0;

  initial rxPin = 1'b1;

  // outgoing bit is still on the line in the tick cycle
  always @(posedge clock) begin
    if (bitTick === 1'b1) begin
      txHist = {txBit, txHist[7:1]};
      onesRun = (txBit === 1'b1) ? onesRun + 1 : 0;
      if (onesRun > maxRun) maxRun = onesRun;
      if (txHist === dl_pkg::FLAG_OCTET) flagCnt++;
    end
  end

  task automatic clearStats;
    onesRun = 0;
    maxRun = 0;
    flagCnt = 0;
  endtask

  // one inbound bit, launched just after a tick edge
  task automatic putBit(input logic b);
    do @(negedge clock); while (bitTick !== 1'b1);
    @(posedge clock);
    rxPin <= b;
  endtask

  task automatic putByte(input logic [7:0] v, input bit stuff);
    for (int i = 0; i < 8; i++) begin
      putBit(v[i]);
      stuffRun = v[i] ? stuffRun + 1 : 0;
      if (stuff && stuffRun == 5) begin
        putBit(1'b0);
        stuffRun = 0;
      end
    end
  endtask

  // three payload bytes plus check sequence; badFcs corrupts it
  task automatic sendFrame(input logic [7:0] d [3], input bit badFcs);
    logic [15:0] crc;
    crc = dl_pkg::CRC_INIT;
    putByte(dl_pkg::FLAG_OCTET, 1'b0);
    stuffRun = 0;
    for (int k = 0; k < 3; k++) begin
      putByte(d[k], 1'b1);
      for (int i = 0; i < 8; i++) begin
        if (crc[0] ^ d[k][i]) crc = (crc >> 1) ^ dl_pkg::CRC_POLY;
        else crc = crc >> 1;
      end
    end
    crc = ~crc ^ {15'h0000, badFcs};
    putByte(crc[7:0], 1'b1);
    putByte(crc[15:8], 1'b1);
    putByte(dl_pkg::FLAG_OCTET, 1'b0);
    // seven marks take the line back to idle and close the receive frame
    repeat (7) putBit(1'b1);
  endtask

  // bit-oriented code: eight ones, 0, six code bits, 0
  task automatic sendCode(input logic [5:0] c);
    putByte(8'hFF, 1'b0);
    putBit(1'b0);
    for (int i = 0; i < 6; i++) putBit(c[i]);
    putBit(1'b0);
    putBit(1'b1);
  endtask
endmodule

// [bench/tb_datalink_hdlc_abort_fcs_ctrl.sv]
// self-checking bench for the data-link hdlc controller
`timescale 1ns/100ps
module tb_datalink_hdlc_abort_fcs_ctrl;
  localparam int BIT_DIV = 4;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe = 1'b0;
  logic [3:0]  wbAdr = 4'h0;
  logic [3:0]  wbSel = 4'hF;
  logic [31:0] wbDatI = 32'h00000000;
  logic [31:0] wbDatO;
  logic        wbAck;
  logic        rxPin;
  logic        txBit;
  logic        bitTick;
  int          errTotal = 0;
  int          nCompared = 0;
  int          frm = 0;
  int          dup = 0;
  int          bad = 0;
  logic [7:0]  frameA [3] = '{8'h11, 8'h22, 8'h33};

  always #5 clock = ~clock;

  datalink_hdlc_abort_fcs_ctrl #(.BIT_DIV(BIT_DIV), .DEPTH(64)) i_dut (
    .clock(clock), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO),
    .wbAck(wbAck), .rxPin(rxPin), .txBit(txBit), .bitTick(bitTick));

  dl_remote_term i_far (
    .clock(clock), .bitTick(bitTick), .txBit(txBit), .rxPin(rxPin));

  task automatic conclude;
    $display("compared %0d, mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one classic cycle; waits for ack, takes data at that edge
  task automatic busCycle(input logic [3:0] adr, input logic we,
                          input logic [31:0] dat, output logic [31:0] rd);
    int n;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 5000);
    if (n >= 5000) check(32'h00000000, 32'h00000001, "bus ack timeout");
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
    logic [31:0] v;
    busCycle(adr, 1'b1, dat, v);
  endtask

  task automatic chkReg(input logic [3:0] adr, input logic [31:0] mask,
                        input logic [31:0] exp, input string what);
    logic [31:0] v;
    busCycle(adr, 1'b0, 32'h00000000, v);
    check(v & mask, exp, what);
  endtask

  task automatic waitBits(input int n);
    repeat (n * BIT_DIV) @(posedge clock);
  endtask

  task automatic chkCounts(input string what);
    chkReg(dl_pkg::COUNT_OFS, 32'h00FFFFFF,
           {8'h00, 8'(bad), 8'(dup), 8'(frm)}, what);
  endtask

  task automatic regTest;
    chkReg(dl_pkg::CTRL_OFS, 32'h000000FF, 32'h00000000, "ctrl reset");
    wr(dl_pkg::CTRL_OFS, 32'h0000007F);
    chkReg(dl_pkg::CTRL_OFS, 32'h000000FF, 32'h0000007F, "ctrl rw");
    wr(4'h2, 32'h000000FF);
    chkReg(dl_pkg::CTRL_OFS, 32'h000000FF, 32'h0000007F, "ctrl kept");
    chkReg(4'h1, 32'hFFFFFFFF, 32'h00000000, "unmapped read");
    wr(dl_pkg::CTRL_OFS, 32'h00000001);
  endtask

  task automatic idleTest;
    i_far.clearStats();
    waitBits(64);
    check(32'(i_far.flagCnt >= 7), 32'h00000001, "idle flags");
    check(32'(i_far.maxRun), 32'h00000006, "no abort idle");
  endtask

  task automatic forceTest;
    wr(dl_pkg::CTRL_OFS, 32'h00000009);
    i_far.clearStats();
    waitBits(24);
    check(32'(i_far.maxRun >= 15), 32'h00000001, "forced ones");
    chkReg(dl_pkg::STATUS_OFS, 32'h00000003, 32'h00000002, "abort state");
    wr(dl_pkg::CTRL_OFS, 32'h00000001);
    waitBits(8);
    i_far.clearStats();
    waitBits(32);
    check(32'(i_far.flagCnt >= 3), 32'h00000001, "flags resume");
    check(32'(i_far.maxRun), 32'h00000006, "no abort resumed");
  endtask

  // cut a frame over to bit-oriented mode with buffer full
  task automatic switchTest(input bit autoOff);
    logic [31:0] v;
    wr(dl_pkg::CTRL_OFS, autoOff ? 32'h00000041 : 32'h00000001);
    waitBits(8);
    i_far.clearStats();
    repeat (4) wr(dl_pkg::TXDATA_OFS, 32'h00000000);
    chkReg(dl_pkg::TXDATA_OFS, 32'h00000003, 32'h00000002, "buffer full");
    wr(dl_pkg::CTRL_OFS, autoOff ? 32'h00000040 : 32'h00000000);
    waitBits(24);
    if (autoOff) check(32'(i_far.maxRun), 32'h00000006, "no abort");
    else check(32'(i_far.maxRun), 32'h00000007, "auto abort");
    for (int i = 0; i < 100; i++) begin
      busCycle(dl_pkg::TXDATA_OFS, 1'b0, 32'h00000000, v);
      if (v[1:0] === 2'b00) break;
    end
    check(v & 32'h00000003, 32'h00000000, "buffer drained");
  endtask

  // raw bytes in bit-oriented mode carry no stuffing
  task automatic bosRawTest;
    wr(dl_pkg::CTRL_OFS, 32'h00000000);
    i_far.clearStats();
    wr(dl_pkg::TXDATA_OFS, 32'h000000FF);
    wr(dl_pkg::TXDATA_OFS, 32'h000000FF);
    waitBits(28);
    check(32'(i_far.maxRun >= 16), 32'h00000001, "raw ones");
  endtask

  task automatic rxTest;
    wr(dl_pkg::CTRL_OFS, 32'h00000001);
    i_far.sendFrame(frameA, 1'b0);
    frm++;
    waitBits(2);
    chkCounts("good frame");
    i_far.sendFrame(frameA, 1'b1);
    bad++;
    waitBits(2);
    chkCounts("bad fcs");
    wr(dl_pkg::CTRL_OFS, 32'h00000021);
    i_far.sendFrame(frameA, 1'b1);
    frm++;
    waitBits(2);
    chkCounts("check off");
    wr(dl_pkg::CTRL_OFS, 32'h00000011);
    i_far.sendFrame(frameA, 1'b0);
    frm++;
    i_far.sendFrame(frameA, 1'b0);
    dup++;
    waitBits(2);
    chkCounts("duplicate drop");
    wr(dl_pkg::CTRL_OFS, 32'h00000001);
    i_far.sendFrame(frameA, 1'b0);
    frm++;
    waitBits(2);
    chkCounts("drop off");
    wr(dl_pkg::CTRL_OFS, 32'h00000011);
    i_far.sendCode(6'h05);
    waitBits(2);
    chkReg(dl_pkg::STATUS_OFS, 32'h007F0000, 32'h00450000, "code seen");
    i_far.sendCode(6'h05);
    dup++;
    waitBits(2);
    chkCounts("code duplicate");
  endtask

  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    regTest();
    idleTest();
    forceTest();
    switchTest(1'b0);
    switchTest(1'b1);
    bosRawTest();
    rxTest();
    conclude();
  end

  initial begin
    repeat (60000) @(posedge clock);
    errTotal++;
    $display("Error at %0t: watchdog expired", $time);
    conclude();
  end
endmodule

// [hw/datalink_hdlc_abort_fcs_ctrl.sv]
// data-link transmit/receive hdlc controller with abort and fcs control
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
module datalink_hdlc_abort_fcs_ctrl #(
  parameter int BIT_DIV = dl_pkg::LINK_BIT_CYCLES,
  parameter int DEPTH   = 64
) (
  // clock and reset
  input  logic        clock,
  input  logic        rst,
  // wishbone slave
  input  logic        wbCyc,
  input  logic        wbStb,
  input  logic        wbWe,
  input  logic [3:0]  wbAdr,
  input  logic [3:0]  wbSel,
  input  logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic        wbAck,
  // data link
  input  logic        rxPin,
  output logic        txBit,
  output logic        bitTick
);
  localparam int AW    = $clog2(DEPTH);
  localparam int DIV_W = $clog2(BIT_DIV + 1);

  function automatic logic [15:0] crcByte(input logic [15:0] c,
                                          input logic [7:0]  d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ dl_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // bit-rate divider
  logic [DIV_W-1:0] divCnt_r, divCnt_nxt;
  always_comb begin
    divCnt_nxt = divCnt_r + DIV_W'(1);
    if (divCnt_r == DIV_W'(BIT_DIV - 1)) begin
      divCnt_nxt = '0;
    end
  end
  always_ff @(posedge clock) begin
    divCnt_r <= rst ? '0 : divCnt_nxt;
  end
  assign bitTick = (divCnt_r == DIV_W'(BIT_DIV - 1));

  // bus, control register and two-entry transmit buffer
  logic [7:0]  ctrl_r, ctrl_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] datO_r, datO_nxt;
  logic [8:0]  ent0_r, ent0_nxt, ent1_r, ent1_nxt;
  logic [1:0]  fifoCnt_r, fifoCnt_nxt;
  logic        hit, txWrite, push, pop, fifoValid, fifoReady;
  logic [31:0] statusWord, countWord;

  assign fifoValid = (fifoCnt_r != 2'h0);
  assign fifoReady = (fifoCnt_r != 2'h2);
  assign hit     = wbCyc && wbStb && !ack_r;
  assign txWrite = hit && wbWe && wbAdr == dl_pkg::TXDATA_OFS && wbSel[0];
  assign push    = txWrite && fifoReady;

  always_comb begin
    logic [1:0] left;
    left        = fifoCnt_r - {1'b0, pop};
    ctrl_nxt    = ctrl_r;
    datO_nxt    = datO_r;
    ack_nxt     = hit && (!txWrite || fifoReady);
    ent0_nxt    = pop ? ent1_r : ent0_r;
    ent1_nxt    = ent1_r;
    if (push && left == 2'h0) begin
      ent0_nxt = wbDatI[8:0];
    end else if (push) begin
      ent1_nxt = wbDatI[8:0];
    end
    fifoCnt_nxt = left + {1'b0, push};
    if (ack_nxt && wbWe && wbAdr == dl_pkg::CTRL_OFS && wbSel[0]) begin
      ctrl_nxt = wbDatI[7:0];
    end
    if (ack_nxt && !wbWe) begin
      case (wbAdr)
        dl_pkg::CTRL_OFS:   datO_nxt = {24'h000000, ctrl_r};
        dl_pkg::TXDATA_OFS: datO_nxt = {30'h00000000, fifoCnt_r};
        dl_pkg::STATUS_OFS: datO_nxt = statusWord;
        dl_pkg::COUNT_OFS:  datO_nxt = countWord;
        default:            datO_nxt = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r    <= dl_pkg::CTRL_RESET;
      ack_r     <= 1'b0;
      datO_r    <= 32'h00000000;
      ent0_r    <= 9'h000;
      ent1_r    <= 9'h000;
      fifoCnt_r <= 2'h0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      ack_r     <= ack_nxt;
      datO_r    <= datO_nxt;
      ent0_r    <= ent0_nxt;
      ent1_r    <= ent1_nxt;
      fifoCnt_r <= fifoCnt_nxt;
    end
  end
  assign wbAck  = ack_r;
  assign wbDatO = datO_r;

  logic autoOff, checkOff, dropOn, forceAbort, formatSel;
  assign autoOff    = ctrl_r[dl_pkg::AUTO_ABORT_OFF_BIT];
  assign checkOff   = ctrl_r[dl_pkg::RX_CHECK_OFF_BIT];
  assign dropOn     = ctrl_r[dl_pkg::RX_DUP_DROP_BIT];
  assign forceAbort = ctrl_r[dl_pkg::TX_FORCE_ABORT_BIT];
  assign formatSel  = ctrl_r[dl_pkg::FORMAT_SELECT_BIT];

  // transmitter
  dl_pkg::txState_t txState_r, txState_nxt;
  logic [7:0] txShift_r, txShift_nxt, nb;
  logic [2:0] txLeft_r, txLeft_nxt, txOnes_r, txOnes_nxt;
  logic       txBit_r, txBit_nxt, inFrame_r, inFrame_nxt;
  logic       close_r, close_nxt, stuffNow, boundary;

  assign stuffNow = txState_r == dl_pkg::TX_DATA && txOnes_r == 3'h5;
  assign boundary = bitTick && !forceAbort && !stuffNow && txLeft_r == 3'h0;

  always_comb begin
    txState_nxt = txState_r;
    txShift_nxt = txShift_r;
    txLeft_nxt  = txLeft_r;
    txOnes_nxt  = txOnes_r;
    txBit_nxt   = txBit_r;
    inFrame_nxt = inFrame_r;
    close_nxt   = close_r;
    pop         = 1'b0;
    nb          = dl_pkg::FLAG_OCTET;
    if (bitTick && forceAbort) begin
      txBit_nxt   = 1'b1;
      txState_nxt = dl_pkg::TX_ABORT;
      txLeft_nxt  = 3'h0;
      txOnes_nxt  = 3'h0;
      inFrame_nxt = 1'b0;
      close_nxt   = 1'b0;
    end else if (bitTick && stuffNow) begin
      txBit_nxt  = 1'b0;
      txOnes_nxt = 3'h0;
    end else if (bitTick && txLeft_r != 3'h0) begin
      txBit_nxt   = txShift_r[0];
      txShift_nxt = {1'b0, txShift_r[7:1]};
      txLeft_nxt  = txLeft_r - 3'h1;
      txOnes_nxt  = (txState_r == dl_pkg::TX_DATA && txShift_r[0]) ?
                    txOnes_r + 3'h1 : 3'h0;
    end else if (boundary) begin
      txState_nxt = dl_pkg::TX_FLAG;
      if (inFrame_r && !formatSel) begin
        inFrame_nxt = 1'b0;
        close_nxt   = 1'b0;
        if (!autoOff) begin
          nb          = dl_pkg::ABORT_OCTET;
          txState_nxt = dl_pkg::TX_ABORT;
        end
      end else if (close_r) begin
        inFrame_nxt = 1'b0;
        close_nxt   = 1'b0;
      end else if (inFrame_r && fifoValid) begin
        nb          = ent0_r[7:0];
        txState_nxt = dl_pkg::TX_DATA;
        pop         = 1'b1;
        close_nxt   = ent0_r[dl_pkg::TXDATA_LAST_BIT];
      end else if (!inFrame_r && fifoValid && formatSel) begin
        inFrame_nxt = 1'b1;
      end else if (!inFrame_r && fifoValid) begin
        nb          = ent0_r[7:0];
        txState_nxt = dl_pkg::TX_BOS;
        pop         = 1'b1;
      end
      txBit_nxt   = nb[0];
      txShift_nxt = {1'b0, nb[7:1]};
      txLeft_nxt  = 3'h7;
      txOnes_nxt  = (txState_nxt == dl_pkg::TX_DATA && nb[0]) ? 3'h1 : 3'h0;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      txState_r <= dl_pkg::TX_FLAG;
      txShift_r <= 8'h00;
      txLeft_r  <= 3'h0;
      txOnes_r  <= 3'h0;
      txBit_r   <= 1'b1;
      inFrame_r <= 1'b0;
      close_r   <= 1'b0;
    end else begin
      txState_r <= txState_nxt;
      txShift_r <= txShift_nxt;
      txLeft_r  <= txLeft_nxt;
      txOnes_r  <= txOnes_nxt;
      txBit_r   <= txBit_nxt;
      inFrame_r <= inFrame_nxt;
      close_r   <= close_nxt;
    end
  end
  assign txBit = txBit_r;

  // receiver
  logic        rxMeta_r, rxSync_r;
  logic [15:0] raw_r, raw_nxt, crc_r, crc_nxt;
  logic [7:0]  acc_r, acc_nxt, frameCnt_r, frameCnt_nxt, dupCnt_r, dupCnt_nxt;
  logic [7:0]  fcsErr_r, fcsErr_nxt, pendData_r, pendData_nxt;
  logic [AW:0] idx_r, idx_nxt, storedLen_r, storedLen_nxt;
  logic [2:0]  cnt_r, cnt_nxt, ones_r, ones_nxt;
  logic        rxIn_r, rxIn_nxt, match_r, match_nxt, pend_r, pend_nxt;
  logic        over_r, over_nxt, stored_r, stored_nxt;
  logic [5:0]  bosCode_r, bosCode_nxt;
  logic        bosValid_r, bosValid_nxt, rdEn, rxEnd, bosHit, lenOk, isDup;
  logic [7:0]  memRd;

  assign raw_nxt = bitTick ? {rxSync_r, raw_r[15:1]} : raw_r;
  // an all-ones code is only a flag after idle marks, never a code
  assign bosHit  = bitTick && raw_nxt[7:0] == 8'hFF && !raw_nxt[8] &&
                   !raw_nxt[15] && raw_nxt[14:9] != 6'h3F;
  assign rxEnd   = bitTick && raw_nxt[15:8] == dl_pkg::FLAG_OCTET && rxIn_r;
  assign lenOk   = idx_r >= (AW+1)'(dl_pkg::MIN_FRAME) && !over_r;
  assign isDup   = dropOn && stored_r && match_r && idx_r == storedLen_r;

  always_comb begin
    logic [7:0] accB;
    accB         = {rxSync_r, acc_r[7:1]};
    acc_nxt      = acc_r;
    crc_nxt      = crc_r;
    idx_nxt      = idx_r;
    cnt_nxt      = cnt_r;
    ones_nxt     = ones_r;
    rxIn_nxt     = rxIn_r;
    match_nxt    = match_r;
    over_nxt     = over_r;
    pend_nxt     = 1'b0;
    pendData_nxt = pendData_r;
    rdEn         = 1'b0;
    stored_nxt   = stored_r;
    storedLen_nxt = storedLen_r;
    frameCnt_nxt = frameCnt_r;
    dupCnt_nxt   = dupCnt_r;
    fcsErr_nxt   = fcsErr_r;
    bosCode_nxt  = bosCode_r;
    bosValid_nxt = bosValid_r;
    if (pend_r && memRd != pendData_r) begin
      match_nxt = 1'b0;
    end
    if (bosHit && dropOn && bosValid_r && raw_nxt[14:9] == bosCode_r) begin
      dupCnt_nxt = dupCnt_r + 8'h01;
    end else if (bosHit) begin
      bosCode_nxt  = raw_nxt[14:9];
      bosValid_nxt = 1'b1;
    end
    if (rxEnd && lenOk && (checkOff || crc_r == dl_pkg::CRC_GOOD)) begin
      if (isDup) begin
        dupCnt_nxt = dupCnt_r + 8'h01;
      end else begin
        stored_nxt    = 1'b1;
        storedLen_nxt = idx_r;
        frameCnt_nxt  = frameCnt_r + 8'h01;
      end
    end else if (rxEnd && lenOk) begin
      fcsErr_nxt = fcsErr_r + 8'h01;
      stored_nxt = 1'b0;
    end else if (rxEnd && idx_r != '0) begin
      stored_nxt = 1'b0;
    end
    if (bitTick && raw_nxt[15:8] == dl_pkg::FLAG_OCTET) begin
      rxIn_nxt  = 1'b1;
      idx_nxt   = '0;
      cnt_nxt   = 3'h0;
      ones_nxt  = 3'h0;
      crc_nxt   = dl_pkg::CRC_INIT;
      match_nxt = 1'b1;
      over_nxt  = 1'b0;
    end else if (bitTick && raw_nxt[15:9] == 7'h7F) begin
      rxIn_nxt = 1'b0;
      if (rxIn_r && idx_r != '0) begin
        stored_nxt = 1'b0;
      end
    end else if (bitTick && rxIn_r && ones_r == 3'h5 && !rxSync_r) begin
      ones_nxt = 3'h0;
    end else if (bitTick && rxIn_r) begin
      ones_nxt = rxSync_r ? ones_r + 3'h1 : 3'h0;
      acc_nxt  = accB;
      cnt_nxt  = cnt_r + 3'h1;
      if (cnt_r == 3'h7) begin
        crc_nxt = crcByte(crc_r, accB);
        idx_nxt = idx_r + (AW+1)'(1);
        if (idx_r < (AW+1)'(DEPTH)) begin
          rdEn         = 1'b1;
          pend_nxt     = 1'b1;
          pendData_nxt = accB;
        end else begin
          over_nxt = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clock) begin
    rxMeta_r <= rst ? 1'b1 : rxPin;
    rxSync_r <= rst ? 1'b1 : rxMeta_r;
    if (rst) begin
      raw_r <= 16'h0000;  crc_r <= dl_pkg::CRC_INIT;  acc_r <= 8'h00;
      idx_r <= '0;  cnt_r <= 3'h0;  ones_r <= 3'h0;  rxIn_r <= 1'b0;
      match_r <= 1'b0;  pend_r <= 1'b0;  pendData_r <= 8'h00;
      over_r <= 1'b0;  stored_r <= 1'b0;  storedLen_r <= '0;
      frameCnt_r <= 8'h00;  dupCnt_r <= 8'h00;  fcsErr_r <= 8'h00;
      bosCode_r <= 6'h00;  bosValid_r <= 1'b0;
    end else begin
      raw_r <= raw_nxt;  crc_r <= crc_nxt;  acc_r <= acc_nxt;
      idx_r <= idx_nxt;  cnt_r <= cnt_nxt;  ones_r <= ones_nxt;
      rxIn_r <= rxIn_nxt;  match_r <= match_nxt;  pend_r <= pend_nxt;
      pendData_r <= pendData_nxt;  over_r <= over_nxt;
      stored_r <= stored_nxt;  storedLen_r <= storedLen_nxt;
      frameCnt_r <= frameCnt_nxt;  dupCnt_r <= dupCnt_nxt;
      fcsErr_r <= fcsErr_nxt;  bosCode_r <= bosCode_nxt;
      bosValid_r <= bosValid_nxt;
    end
  end

  // the store is written with every received frame, not only accepted ones, and is read for duplicate compare
  dl_frame_mem #(.WIDTH(8), .DEPTH(DEPTH)) frameStore (
    .clock  (clock),
    .wrEn   (pend_r),
    .wrAddr (AW'(idx_r - (AW+1)'(1))),
    .wrData (pendData_r),
    .rdEn   (rdEn),
    .rdAddr (idx_r[AW-1:0]),
    .rdData (memRd)
  );

  assign statusWord = {9'h000, bosValid_r, bosCode_r, 8'(storedLen_r),
                       5'h00, stored_r, txState_r};
  assign countWord  = {8'h00, fcsErr_r, dupCnt_r, frameCnt_r};

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence abortStartS;
    boundary && inFrame_r && !formatSel && !close_r;
  endsequence
  sequence abortZeroS;
    txState_r == dl_pkg::TX_ABORT && !txBit_r && txLeft_r == 3'h7;
  endsequence

  auto_abort_a: assert property (abortStartS ##0 !autoOff |=> abortZeroS)
    else $error("auto abort did not start with a zero");
  abort_ones_a: assert property (txState_r == dl_pkg::TX_ABORT && bitTick
    && txLeft_r != 3'h0 && !forceAbort |=> txBit_r)
    else $error("abort sequence bit not one");
  no_abort_a: assert property (abortStartS ##0 autoOff |=>
    txState_r == dl_pkg::TX_FLAG && !inFrame_r)
    else $error("abort sent while auto abort off");
  fcs_fail_a: assert property (rxEnd && lenOk && !checkOff &&
    crc_r != dl_pkg::CRC_GOOD |=> !stored_r &&
    fcsErr_r == $past(fcsErr_r) + 8'h01)
    else $error("bad fcs frame not rejected");
  fcs_skip_a: assert property (rxEnd && lenOk && checkOff |=> stored_r)
    else $error("frame rejected with check disabled");
  dup_drop_a: assert property (rxEnd && lenOk && isDup && !bosHit &&
    (checkOff || crc_r == dl_pkg::CRC_GOOD) |=>
    frameCnt_r == $past(frameCnt_r) && dupCnt_r == $past(dupCnt_r) + 8'h01)
    else $error("duplicate frame not dropped");
  no_drop_a: assert property (!dropOn |=> dupCnt_r == $past(dupCnt_r))
    else $error("frame dropped with drop off");
  force_ones_a: assert property (forceAbort && bitTick |=>
    txBit_r && !inFrame_r)
    else $error("forced abort not sending ones");
  normal_shift_a: assert property (!forceAbort && bitTick &&
    !stuffNow && txLeft_r != 3'h0 |=> txBit_r == $past(txShift_r[0]))
    else $error("transmit bit out of order");
  format_bos_a: assert property (boundary && !inFrame_r && !close_r &&
    fifoValid && !formatSel |=> txState_r == dl_pkg::TX_BOS)
    else $error("bit-oriented send not taken");
  idle_flag_a: assert property (boundary && !inFrame_r && !close_r &&
    !fifoValid |=> !txBit_r && txShift_r == 8'h3F)
    else $error("idle flag not sent");
  ack_pulse_a: assert property (wbAck |=> !wbAck)
    else $error("ack longer than one cycle");
endmodule

// [hw/dl_frame_mem.sv]
// receive frame store with registered read data
`timescale 1ns/100ps
module dl_frame_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  // clock
  input  logic                     clock,
  // write port
  input  logic                     wrEn,
  input  logic [$clog2(DEPTH)-1:0] wrAddr,
  input  logic [WIDTH-1:0]         wrData,
  // read port
  input  logic                     rdEn,
  input  logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic [WIDTH-1:0]         rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule

// [hw/dl_pkg.sv]
// constants, register map and types for the data-link controller
package dl_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] TXDATA_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] COUNT_OFS  = 4'hC;
  // control register fields
  localparam int         AUTO_ABORT_OFF_BIT  = 6;
  localparam int         RX_CHECK_OFF_BIT    = 5;
  localparam int         RX_DUP_DROP_BIT     = 4;
  localparam int         TX_FORCE_ABORT_BIT  = 3;
  localparam int         FORMAT_SELECT_BIT   = 0;
  localparam logic [7:0] CTRL_RESET          = 8'h00;
  // transmit data register fields
  localparam int         TXDATA_LAST_BIT     = 8;
  // timing
  localparam int         CLOCK_PERIOD_NS     = 10;
  localparam int         LINK_BIT_PERIOD_NS  = 250000;
  localparam int         LINK_BIT_CYCLES     =
    LINK_BIT_PERIOD_NS / CLOCK_PERIOD_NS;
  // line patterns
  localparam logic [7:0]  FLAG_OCTET   = 8'h7E;
  localparam logic [7:0]  ABORT_OCTET  = 8'hFE;
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] CRC_GOOD     = 16'hF0B8;
  localparam logic [15:0] CRC_POLY     = 16'h8408;
  localparam int          MIN_FRAME    = 3;
  typedef enum logic [1:0] {TX_FLAG, TX_DATA, TX_ABORT, TX_BOS} txState_t;
endpackage
